//--- logic/irrt_pkg.sv
// Package: register map, field layout and timing constants of the IR road-train receiver
package irrt_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int LOSS_TIME_MS = 2000;
   localparam int LOSS_CYCLES = CLK_HZ / 1000 * LOSS_TIME_MS;
   localparam int PAUSE_TIME_MS = 3000;
   localparam int PAUSE_CYCLES = CLK_HZ / 1000 * PAUSE_TIME_MS;
   localparam int BLINK_TIME_MS = 100;
   localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_TIME_MS;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_LIGHTS = 8'h10;
   localparam logic [7:0] REG_MOTOR = 8'h14;
   localparam int CTRL_ADDR_LSB = 0;
   localparam int CTRL_HOLD_BIT = 3;
   localparam int CTRL_RELAY_BIT = 4;
   localparam int CTRL_MSPD_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_6600;
   localparam logic [7:0] SERVO_NEUTRAL = 8'h80;
   localparam int EV_LOSS = 0;
   localparam int EV_FRAME = 1;
   localparam int EV_LOC = 2;
   localparam int EV_MOC = 3;

   typedef enum logic [3:0] {
      IRRT_CMD_LIGHTS, IRRT_CMD_SERVO, IRRT_CMD_MOTOR, IRRT_CMD_ADDR
   } irrt_cmd_t;

   typedef struct packed {
      logic valid;
      irrt_cmd_t cmd;
      logic [1:0] index;
      logic [15:0] data;
   } irrt_frame_t;
endpackage : irrt_pkg

//--- logic/irrt_receiver.sv
// IR command receiver: applies frames to lights, servos and motor, link watchdog, LED, relay
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module irrt_receiver
   import irrt_pkg::*;
#(
   parameter int LOSS_CYC = LOSS_CYCLES,
   parameter int PAUSE_CYC = PAUSE_CYCLES,
   parameter int BLINK_CYC = BLINK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire irrt_frame_t frame,
   input wire logic ir_in,
   input wire logic manual_sw,
   input wire logic light_oc,
   input wire logic motor_oc,
   output logic aux_out,
   output logic [15:0] lights,
   output logic [31:0] servo_pos,
   output logic [7:0] motor_speed,
   output logic motor_dir,
   output logic status_led,
   output logic irq
);
   logic [1:0] ir_sync, sw_sync, loc_sync, moc_sync;
   logic [31:0] ctrl, next_ctrl;
   logic [3:0] ist, next_ist, imask, next_imask;
   logic [2:0] sel_addr, next_sel_addr;
   logic [15:0] next_lights;
   logic [31:0] next_servo;
   logic [7:0] rm_speed, next_rm_speed;
   logic rm_dir, next_rm_dir;
   logic [31:0] wd_cnt, next_wd_cnt;
   logic link_ok, next_link_ok;
   logic [31:0] led_cnt, next_led_cnt;
   logic [3:0] blink_n, next_blink_n;
   logic led, next_led;
   logic wr, rd, addr_ok, cmd_ok;
   logic [3:0] ev;
   logic [2:0] own_addr;
   logic [7:0] next_motor_speed;
   logic next_motor_dir;
   logic [31:0] next_prdata;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !pwrite;
   assign pready = 1'b1;
   assign addr_ok = paddr inside {REG_CTRL, REG_STATUS, REG_IRQ_STAT, REG_IRQ_MASK,
                                  REG_LIGHTS, REG_MOTOR};
   assign pslverr = psel && penable && !addr_ok;
   assign own_addr = ctrl[CTRL_ADDR_LSB +: 3];
   assign cmd_ok = (sel_addr == 3'h0) || (sel_addr == own_addr);
   assign irq = |(ist & imask);
   assign status_led = led;
   assign aux_out = ctrl[CTRL_RELAY_BIT] && ir_sync[1];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir_sync <= 2'h0;
         sw_sync <= 2'h0;
         loc_sync <= 2'h0;
         moc_sync <= 2'h0;
      end else begin
         ir_sync <= {ir_sync[0], ir_in};
         sw_sync <= {sw_sync[0], manual_sw};
         loc_sync <= {loc_sync[0], light_oc};
         moc_sync <= {moc_sync[0], motor_oc};
      end
   end

   always_comb begin
      next_lights = lights;
      next_servo = servo_pos;
      next_rm_speed = rm_speed;
      next_rm_dir = rm_dir;
      next_sel_addr = sel_addr;
      next_wd_cnt = wd_cnt;
      next_link_ok = link_ok;
      ev = 4'h0;
      if (frame.valid) begin
         next_wd_cnt = 32'h0;
         next_link_ok = 1'b1;
         ev[EV_FRAME] = 1'b1;
         case (frame.cmd)
            IRRT_CMD_LIGHTS: next_lights = frame.data;
            IRRT_CMD_ADDR: next_sel_addr = frame.data[2:0];
            IRRT_CMD_SERVO: begin
               if (cmd_ok) begin
                  next_servo[frame.index*8 +: 8] = frame.data[7:0];
               end
            end
            IRRT_CMD_MOTOR: begin
               if (cmd_ok) begin
                  next_rm_speed = frame.data[7:0];
                  next_rm_dir = frame.data[8];
               end
            end
            default: ;
         endcase
      end else if (wd_cnt >= LOSS_CYC - 1) begin
         if (link_ok) begin
            ev[EV_LOSS] = 1'b1;
            next_link_ok = 1'b0;
            next_lights = 16'h0;
            next_rm_speed = 8'h0;
            if (!ctrl[CTRL_HOLD_BIT]) begin
               next_servo = {4{SERVO_NEUTRAL}};
            end
         end
      end else begin
         next_wd_cnt = wd_cnt + 32'h1;
      end
      ev[EV_LOC] = loc_sync[1];
      ev[EV_MOC] = moc_sync[1];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lights <= 16'h0;
         servo_pos <= {4{SERVO_NEUTRAL}};
         rm_speed <= 8'h0;
         rm_dir <= 1'b0;
         sel_addr <= 3'h0;
         wd_cnt <= 32'h0;
         link_ok <= 1'b0;
      end else begin
         lights <= next_lights;
         servo_pos <= next_servo;
         rm_speed <= next_rm_speed;
         rm_dir <= next_rm_dir;
         sel_addr <= next_sel_addr;
         wd_cnt <= next_wd_cnt;
         link_ok <= next_link_ok;
      end
   end

   // Manual switch overrides the remote command while closed
   always_comb begin
      next_motor_speed = next_rm_speed;
      next_motor_dir = next_rm_dir;
      if (sw_sync[1]) begin
         next_motor_speed = ctrl[CTRL_MSPD_LSB +: 8];
         next_motor_dir = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motor_speed <= 8'h0;
         motor_dir <= 1'b0;
      end else begin
         motor_speed <= next_motor_speed;
         motor_dir <= next_motor_dir;
      end
   end

   // Register file; set wins over write-one-to-clear
   always_comb begin
      next_ctrl = ctrl;
      next_imask = imask;
      next_ist = ist;
      if (wr && paddr == REG_CTRL) next_ctrl = pwdata;
      if (wr && paddr == REG_IRQ_MASK) next_imask = pwdata[3:0];
      if (wr && paddr == REG_IRQ_STAT) next_ist = ist & ~pwdata[3:0];
      next_ist = next_ist | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
         imask <= 4'h0;
         ist <= 4'h0;
      end else begin
         ctrl <= next_ctrl;
         imask <= next_imask;
         ist <= next_ist;
      end
   end

   // Read data is loaded in the setup cycle so it stands through the access phase
   always_comb begin
      next_prdata = prdata;
      if (rd && !penable) begin
         case (paddr)
            REG_CTRL: next_prdata = ctrl;
            REG_STATUS: begin
               next_prdata = {24'h0, sel_addr, moc_sync[1], loc_sync[1], led, 1'b0, link_ok};
            end
            REG_IRQ_STAT: next_prdata = {28'h0, ist};
            REG_IRQ_MASK: next_prdata = {28'h0, imask};
            REG_LIGHTS: next_prdata = {16'h0, lights};
            REG_MOTOR: next_prdata = {23'h0, motor_dir, motor_speed};
            default: next_prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else begin
         prdata <= next_prdata;
      end
   end

   // LED: blink_n counts half-periods of an error burst; 0 means normal pattern
   always_comb begin
      next_led_cnt = led_cnt + 32'h1;
      next_led = led;
      next_blink_n = blink_n;
      if (moc_sync[1] || loc_sync[1]) begin
         if (blink_n == 4'h0) begin
            next_blink_n = moc_sync[1] ? 4'h8 : 4'h6;
            next_led_cnt = 32'h0;
            next_led = 1'b1;
         end else if (blink_n == 4'h1) begin
            next_led = 1'b0;
            if (led_cnt >= PAUSE_CYC - 1) begin
               next_blink_n = 4'h0;
            end
         end else if (led_cnt >= BLINK_CYC - 1) begin
            next_led_cnt = 32'h0;
            next_led = !led;
            next_blink_n = blink_n - 4'h1;
         end
      end else begin
         next_blink_n = 4'h0;
         if (!link_ok) begin
            next_led = 1'b1;
            next_led_cnt = 32'h0;
         end else if (led_cnt >= BLINK_CYC - 1) begin
            next_led = !led;
            next_led_cnt = 32'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_cnt <= 32'h0;
         led <= 1'b1;
         blink_n <= 4'h0;
      end else begin
         led_cnt <= next_led_cnt;
         led <= next_led;
         blink_n <= next_blink_n;
      end
   end

   loss_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
      link_ok && !frame.valid && wd_cnt >= LOSS_CYC - 1 |=> lights == 16'h0)
      else $error("lights not cleared on link loss");
   loss_motor_a: assert property (@(posedge pclk) disable iff (!presetn)
      link_ok && !frame.valid && wd_cnt >= LOSS_CYC - 1 && !sw_sync[1]
      |=> motor_speed == 8'h0)
      else $error("motor not stopped on link loss");
   lights_any_a: assert property (@(posedge pclk) disable iff (!presetn)
      frame.valid && frame.cmd == IRRT_CMD_LIGHTS |=> lights == $past(frame.data))
      else $error("light command not applied");
   servo_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      frame.valid && frame.cmd == IRRT_CMD_SERVO && sel_addr != 3'h0 && sel_addr != own_addr
      |=> $stable(servo_pos))
      else $error("servo moved for foreign address");
   servo_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
      frame.valid && frame.cmd == IRRT_CMD_SERVO && sel_addr == 3'h0
      |=> servo_pos[$past(frame.index)*8 +: 8] == $past(frame.data[7:0]))
      else $error("servo command dropped with no address");
   manual_speed_a: assert property (@(posedge pclk) disable iff (!presetn)
      sw_sync[1] |=> motor_speed == $past(ctrl[CTRL_MSPD_LSB +: 8]))
      else $error("manual speed not applied");
   relay_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl[CTRL_RELAY_BIT] |-> aux_out == $past(ir_in, 2))
      else $error("relay output differs from input");
   led_steady_a: assert property (@(posedge pclk) disable iff (!presetn)
      !link_ok && !loc_sync[1] && !moc_sync[1] ##1 !link_ok |-> led)
      else $error("led not steady without link");
   neutral_a: assert property (@(posedge pclk) disable iff (!presetn)
      link_ok && !frame.valid && wd_cnt >= LOSS_CYC - 1 && !ctrl[CTRL_HOLD_BIT]
      |=> servo_pos == {4{SERVO_NEUTRAL}})
      else $error("servos not neutral on loss");
   cv_loss_c: cover property (@(posedge pclk) disable iff (!presetn) ev[EV_LOSS]);
   cv_foreign_c: cover property (@(posedge pclk) disable iff (!presetn)
      frame.valid && !cmd_ok);
   cv_manual_c: cover property (@(posedge pclk) disable iff (!presetn) sw_sync[1]);
endmodule : irrt_receiver

//--- bench/irrt_sender.sv
// Towing vehicle model: decoded frame pulses and the raw IR line
`timescale 1ns/1ps
module irrt_sender
   import irrt_pkg::*;
(
   input wire logic pclk,
   output irrt_frame_t frame,
   output logic ir_in
);
   initial begin
      frame = '0;
      ir_in = 1'b0;
   end
   // Chain address frames carry 0 for none or 1 to 7
   task automatic send(input irrt_cmd_t c, input logic [1:0] ix, input logic [15:0] d);
      @(posedge pclk);
      frame <= '{1'b1, c, ix, d};
      ir_in <= d[0];
      @(posedge pclk);
      frame.valid <= 1'b0;
      // Idle line shows the inverse so a stale bit cannot pass as relayed
      ir_in <= ~d[0];
   endtask : send
endmodule : irrt_sender

//--- bench/tb_top.sv
// Self-checking bench of the IR road-train receiver
`timescale 1ns/1ps
module tb_top;
   import irrt_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0, motor_speed, ex_m = '0, ms;
   logic [31:0] pwdata = '0, prdata, servo_pos, q;
   logic pready, pslverr, ir_in, manual_sw = 0, light_oc = 0, motor_oc = 0;
   logic aux_out, motor_dir, status_led, irq, rly = 0, ex_d = 0;
   logic [15:0] lights, ex_l = '0;
   logic [7:0] ex_s [4] = '{default: 8'h80};
   logic [1:0] ir_h = '0, ix;
   irrt_frame_t frame;
   int seed = 98425, bad_count = 0, cmp_count = 0, cyc = 0, sel = 0, own = 0, tg;
   irrt_sender peer (.pclk(pclk), .frame(frame), .ir_in(ir_in));
   // Long counts shortened so the run stays brief
   irrt_receiver #(.LOSS_CYC(50), .PAUSE_CYC(40), .BLINK_CYC(4)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame(frame),
      .ir_in(ir_in), .manual_sw(manual_sw), .light_oc(light_oc), .motor_oc(motor_oc),
      .aux_out(aux_out), .lights(lights), .servo_pos(servo_pos), .motor_speed(motor_speed),
      .motor_dir(motor_dir), .status_led(status_led), .irq(irq));
   always #25 pclk = ~pclk;
   task automatic stop_test;
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd, input logic e);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      chk(pslverr, e);
      if (w && a == REG_CTRL) rly = wd[CTRL_RELAY_BIT];
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic snd(input irrt_cmd_t c, input logic [15:0] dd);
      ix = 2'($random(seed));
      peer.send(c, ix, dd);
      if (c == IRRT_CMD_LIGHTS) ex_l = dd;
      if (c == IRRT_CMD_ADDR) sel = dd[2:0];
      if (sel == 0 || sel == own) begin
         if (c == IRRT_CMD_SERVO) ex_s[ix] = dd[7:0];
         if (c == IRRT_CMD_MOTOR) {ex_d, ex_m} = dd[8:0];
      end
      #1;
      chk(lights, ex_l);
      chk(servo_pos, {ex_s[3], ex_s[2], ex_s[1], ex_s[0]});
      chk({motor_dir, motor_speed}, {ex_d, ex_m});
   endtask : snd
   task automatic blink(output int n);
      logic p;
      p = status_led;
      n = 0;
      repeat (20) begin
         @(posedge pclk);
         #1;
         if (status_led !== p) n++;
         p = status_led;
      end
   endtask : blink
   always @(posedge pclk) ir_h <= {ir_h[0], ir_in};
   // Two sync stages sit between the IR pin and the relay output
   always @(negedge pclk) if (presetn) chk(aux_out, rly & ir_h[1]);
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         stop_test();
      end
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk(servo_pos, 32'h8080_8080);
      chk({irq, status_led, motor_speed, lights}, 32'h0100_0000);
      apb(REG_CTRL, 1'b0, '0, 1'b0);
      chk(q, CTRL_RESET);
      apb(8'h20, 1'b1, '1, 1'b1);
      apb(8'h20, 1'b0, '0, 1'b1);
      chk(q, '0);
      apb(REG_STATUS, 1'b0, '0, 1'b0);
      chk(q[7:5], 3'h0);
      for (int i = 0; i < 6; i++) snd(irrt_cmd_t'(i % 3), 16'($random(seed)));
      // Relay emitter on the aux port; no configuration traffic on it meanwhile
      apb(REG_CTRL, 1'b1, CTRL_RESET | 32'h13, 1'b0);
      own = 3;
      for (int a = 0; a < 8; a++) begin
         snd(IRRT_CMD_ADDR, 16'(a));
         for (int i = 0; i < 3; i++) snd(irrt_cmd_t'(i), 16'($random(seed)));
      end
      snd(IRRT_CMD_ADDR, 16'h0);
      apb(REG_IRQ_STAT, 1'b1, 32'hF, 1'b0);
      apb(REG_IRQ_MASK, 1'b1, 32'h2, 1'b0);
      snd(IRRT_CMD_LIGHTS, 16'hA5C3);
      chk(irq, 1'b1);
      apb(REG_IRQ_STAT, 1'b1, 32'h2, 1'b0);
      #1;
      chk(irq, 1'b0);
      for (int i = 0; i < 2; i++) begin
         @(posedge pclk);
         {motor_oc, light_oc} <= 2'(i + 1);
         apb(REG_IRQ_MASK, 1'b1, 32'(4 << i), 1'b0);
         #1;
         chk(irq, 1'b1);
         apb(REG_STATUS, 1'b0, '0, 1'b0);
         chk(q[3 + i], 1'b1);
         @(posedge pclk);
         {motor_oc, light_oc} <= 2'b00;
         apb(REG_IRQ_STAT, 1'b1, 32'hC, 1'b0);
         #1;
         chk(irq, 1'b0);
      end
      // Loss interrupt only; frame events would keep the line up
      apb(REG_IRQ_MASK, 1'b1, 32'h1, 1'b0);
      apb(REG_CTRL, 1'b1, CTRL_RESET | 32'h3, 1'b0);
      snd(IRRT_CMD_SERVO, 16'($random(seed)));
      blink(tg);
      chk(tg, 20 / 4);
      repeat (40) @(posedge pclk);
      #1;
      chk({irq, motor_speed, lights}, 32'h0100_0000);
      chk(servo_pos, 32'h8080_8080);
      blink(tg);
      chk({tg[7:0], status_led}, 9'h001);
      ex_s = '{default: 8'h80};
      // Link loss cleared lights and remote speed; the model follows
      ex_l = '0;
      ex_m = '0;
      ms = 8'($random(seed));
      apb(REG_CTRL, 1'b1, {16'h0, ms, 8'h0B}, 1'b0);
      snd(IRRT_CMD_SERVO, 16'($random(seed)));
      repeat (60) @(posedge pclk);
      #1;
      chk(servo_pos, {ex_s[3], ex_s[2], ex_s[1], ex_s[0]});
      chk(lights, 16'h0);
      @(posedge pclk);
      manual_sw <= 1'b1;
      repeat (5) @(posedge pclk);
      #1;
      chk(motor_speed, ms);
      stop_test();
   end
endmodule : tb_top
